/* rtl/fast_ethernet_pcs_codec.sv */
// Behaviour
// (RL1) send idle code-group 11111 while transmit enable stays low after end delimiter
// (RL2) rising transmit enable replaces first two nibbles by 11000 then 10001
// (RL3) never send unassigned code-groups; flag receive error on them during valid
// (RL4) scrambler seed comes from the port's management address
// (RL5) scrambler stage serialises each 5-bit code-group
// (RL6) serial stream is NRZI coded, one bit per symbol period
// (RL7) MLT-3: code bit one steps the level, zero holds it
// (RL8) descrambler takes its key from idle, then locks and descrambles data
// (RL9) after lock an idle must appear within every 40 us window
// (RL10) watchdog expiry aborts reception and restarts descrambler sync
// (RL11) code-group boundaries come from the start delimiter pair
// (RL12) alignment holds until the next start delimiter
// (RL13) data code-groups decode to nibbles on the receive data bus
// (RL14) start delimiter is delivered as nibbles 0101 0101
// (RL15) start delimiter asserts receive data valid
// (RL16) end delimiter or two idles drop carrier sense and data valid
// (RL17) end delimiter and closing idles are not passed as data
// (RL18) nibbles map one-to-one onto sixteen fixed code-groups both ways
// (RL19) transmit error input sends the transmit-error code-group
// (RL20) unexpected code-group in a frame asserts receive error
// (RL21) bad start delimiter gives receive error, nibble 1110, valid low
// (RL22) scrambler is the 11-bit x11+x9+1 stream cipher XORed per bit
// (RL23) one nibble and one code-group every five symbol periods
module fast_ethernet_pcs_codec
	import pcs_codec_pkg::*;
#(
	parameter int WDOG_LIMIT = WDOG_CYC
)
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [pcs_codec_pkg::ADDR_W-1:0] phy_addr_i,
	input wire logic tx_en_i,
	input wire logic tx_er_i,
	input wire logic [pcs_codec_pkg::NIB_W-1:0] txd_i,
	output logic tx_take_o,
	output logic [pcs_codec_pkg::LVL_W-1:0] tx_level_o,
	input wire logic [pcs_codec_pkg::LVL_W-1:0] rx_level_i,
	output logic [pcs_codec_pkg::NIB_W-1:0] rxd_o,
	output logic rx_dv_o,
	output logic rx_er_o,
	output logic crs_o,
	output logic rx_lock_o
);
	import pcs_codec_pkg::*;

	typedef enum logic [1:0] {TX_IDLE, TX_SSD2, TX_DATA, TX_ESD2} tx_state_t;

	typedef struct packed {
		logic phase;
		logic [2:0] bit_idx;
		tx_state_t tx_st;
		logic [4:0] tx_grp;
		logic [4:0] tx_cur;
		logic [10:0] scr;
		logic seeded;
		logic nrzi;
		logic [1:0] mlt_step;
		logic [1:0] tx_lvl;
		logic take;
		logic [1:0] sync1;
		logic [1:0] sync2;
		logic [1:0] prev_lvl;
		logic [10:0] dscr;
		logic lock;
		logic [5:0] acq_cnt;
		logic [14:0] hist;
		logic in_frame;
		logic [2:0] algn;
		logic esd_seen;
		logic [1:0] idle_cnt;
		logic [3:0] pend_nib;
		logic pend_dv;
		logic pend_er;
		logic [3:0] rxd;
		logic dv;
		logic er;
		logic crs;
		logic [15:0] wdog;
	} state_t;

	localparam logic [15:0] WDOG_LAST = 16'(WDOG_LIMIT - 1);

	state_t q;
	state_t d;
	logic [4:0] enc_cg_w;
	logic [4:0] dec_cg_w;
	logic [3:0] dec_nib_w;
	logic dec_data_w;
	logic tick_w;
	logic tx_fb_w;
	logic rx_pred_w;
	logic rx_cb_w;
	logic rx_plain_w;
	logic [14:0] hist_n_w;

	assign tick_w = q.phase;
	assign tx_fb_w = q.scr[LFSR_W-1] ^ q.scr[LFSR_TAP]; // RL22
	assign rx_pred_w = q.dscr[LFSR_W-1] ^ q.dscr[LFSR_TAP];
	// any change of level is a code bit of one
	assign rx_cb_w = (q.sync2 != q.prev_lvl);
	assign rx_plain_w = rx_cb_w ^ rx_pred_w;
	assign hist_n_w = {q.hist[13:0], rx_plain_w};
	assign dec_cg_w = hist_n_w[4:0];

	nibble_code_map u_map (
		.enc_nib_i(txd_i),
		.enc_cg_o(enc_cg_w),
		.dec_cg_i(dec_cg_w),
		.dec_nib_o(dec_nib_w),
		.dec_data_o(dec_data_w)
	);

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		d = q;
		d.phase = ~q.phase;
		d.sync1 = rx_level_i;
		d.sync2 = q.sync1;
		// MAC inputs are sampled in the cycle this pulse is high
		d.take = ~q.phase && (q.bit_idx == LAST_BIT); // RL23

		// transmit: seed, serialise, scramble, line code
		d.seeded = 1'b1;
		if (!q.seeded)
			d.scr = {~phy_addr_i, SEED_PAD}; // RL4
		else if (tick_w)
		begin
			d.scr = {q.scr[LFSR_W-2:0], tx_fb_w}; // RL22
			if (q.tx_grp[4] ^ tx_fb_w) // RL5 RL22
			begin
				d.nrzi = ~q.nrzi; // RL6
				d.mlt_step = q.mlt_step + 2'h1; // RL7
			end
			d.tx_grp = {q.tx_grp[3:0], 1'b0}; // RL5
			d.bit_idx = q.bit_idx + 3'h1;
			if (q.bit_idx == LAST_BIT)
			begin
				d.bit_idx = 3'h0;
				unique case (q.tx_st)
					TX_IDLE:
					begin
						d.tx_grp = CG_IDLE; // RL1
						if (tx_en_i)
						begin
							d.tx_grp = CG_SSD1; // RL2
							d.tx_st = TX_SSD2;
						end
					end
					TX_SSD2:
					begin
						d.tx_grp = CG_SSD2; // RL2
						d.tx_st = TX_DATA;
					end
					TX_DATA:
					begin
						if (!tx_en_i)
						begin
							d.tx_grp = CG_ESD1;
							d.tx_st = TX_ESD2;
						end
						else if (tx_er_i)
							d.tx_grp = CG_TXERR; // RL19
						else
							d.tx_grp = enc_cg_w; // RL18
					end
					TX_ESD2:
					begin
						d.tx_grp = CG_ESD2;
						d.tx_st = TX_IDLE;
					end
				endcase
				d.tx_cur = d.tx_grp;
			end
		end
		unique case (q.mlt_step)
			2'h1: d.tx_lvl = LVL_POS;
			2'h3: d.tx_lvl = LVL_NEG;
			default: d.tx_lvl = LVL_ZERO;
		endcase

		// receive: one line symbol per tick
		if (tick_w)
		begin
			d.prev_lvl = q.sync2;
			if (!q.lock)
			begin
				// idle is all ones, so the key bit is the inverted line bit
				d.dscr = {q.dscr[LFSR_W-2:0], ~rx_cb_w}; // RL8
				d.acq_cnt = (rx_pred_w == ~rx_cb_w) ? q.acq_cnt + 6'h1 : 6'h0;
				if (q.acq_cnt == LOCK_RUN)
				begin
					d.lock = 1'b1; // RL8
					d.wdog = 16'h0;
				end
			end
			else
			begin
				d.dscr = {q.dscr[LFSR_W-2:0], rx_pred_w}; // RL8
				d.hist = hist_n_w;
				if (!q.in_frame)
				begin
					d.dv = 1'b0;
					d.er = 1'b0;
					if (hist_n_w[9:0] == {CG_SSD1, CG_SSD2})
					begin
						d.in_frame = 1'b1; // RL11
						d.crs = 1'b1;
						d.algn = 3'h0;
						d.rxd = NIB_PREAMBLE; // RL14
						d.dv = 1'b1; // RL15
						d.pend_nib = NIB_PREAMBLE; // RL14
						d.pend_dv = 1'b1;
						d.pend_er = 1'b0;
						d.esd_seen = 1'b0;
						d.idle_cnt = 2'h0;
					end
					else if (hist_n_w[14:5] == {CG_IDLE, CG_SSD1})
					begin
						d.rxd = NIB_BAD_SSD; // RL21
						d.er = 1'b1; // RL21
					end
				end
				else
				begin
					// alignment is frozen for the whole frame
					d.algn = q.algn + 3'h1; // RL12
					if (q.algn == LAST_BIT)
					begin
						d.algn = 3'h0;
						d.rxd = q.pend_nib; // RL13
						d.dv = q.pend_dv;
						d.er = q.pend_er;
						d.pend_nib = dec_nib_w;
						d.pend_dv = 1'b1;
						d.pend_er = 1'b0;
						d.idle_cnt = 2'h0;
						d.esd_seen = 1'b0;
						if (q.esd_seen && dec_cg_w == CG_ESD2)
						begin
							d.in_frame = 1'b0; // RL16
							d.crs = 1'b0;
							d.dv = 1'b0;
							d.er = 1'b0;
						end
						else if (dec_cg_w == CG_ESD1)
						begin
							d.esd_seen = 1'b1;
							d.pend_dv = 1'b0; // RL17
						end
						else if (dec_cg_w == CG_IDLE)
						begin
							d.pend_dv = 1'b0; // RL17
							d.idle_cnt = q.idle_cnt + 2'h1;
							if (q.idle_cnt + 2'h1 == IDLE_END_CNT)
							begin
								d.in_frame = 1'b0; // RL16
								d.crs = 1'b0;
								d.dv = 1'b0;
								d.er = 1'b0;
							end
						end
						else if (!dec_data_w)
							d.pend_er = 1'b1; // RL3 RL20
					end
				end
			end
		end

		// watchdog on idle gaps
		if (q.lock)
		begin
			d.wdog = (q.hist[4:0] == CG_IDLE) ? 16'h0 : q.wdog + 16'h1; // RL9
			if (q.wdog == WDOG_LAST)
			begin
				d.lock = 1'b0; // RL10
				d.acq_cnt = 6'h0;
				d.in_frame = 1'b0;
				d.crs = 1'b0;
				d.dv = 1'b0;
				d.er = 1'b0;
				d.wdog = 16'h0;
			end
		end

		if (rst_i)
		begin
			d = '0;
			d.tx_grp = CG_IDLE;
			d.tx_cur = CG_IDLE;
		end
	end

	always_ff @(posedge sys_clk_i)
		q <= d;

	assign tx_take_o = q.take;
	assign tx_level_o = q.tx_lvl;
	assign rxd_o = q.rxd;
	assign rx_dv_o = q.dv;
	assign rx_er_o = q.er;
	assign crs_o = q.crs;
	assign rx_lock_o = q.lock;

	////////////////////////////////////////////////////////////////////////////
	// checks

	property p_idle_fill;
		@(posedge sys_clk_i) disable iff (rst_i)
		tx_take_o && q.tx_st == TX_IDLE && !tx_en_i |=> q.tx_cur == CG_IDLE;
	endproperty
	a_idle_fill: assert property (p_idle_fill) else $error("idle not sent while enable low"); // RL1
	property p_ssd_pair;
		@(posedge sys_clk_i) disable iff (rst_i)
		tx_take_o && q.tx_st == TX_IDLE && tx_en_i |=> q.tx_cur == CG_SSD1 ##10 q.tx_cur == CG_SSD2;
	endproperty
	a_ssd_pair: assert property (p_ssd_pair) else $error("start delimiter pair not sent"); // RL2
	property p_no_invalid_tx;
		@(posedge sys_clk_i) disable iff (rst_i)
		!(q.tx_cur inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h19});
	endproperty
	a_no_invalid_tx: assert property (p_no_invalid_tx) else $error("unassigned code-group sent"); // RL3
	property p_mlt_step;
		@(posedge sys_clk_i) disable iff (rst_i)
		q.seeded && tick_w && (q.tx_grp[4] ^ tx_fb_w) |=> q.mlt_step == $past(q.mlt_step) + 2'h1 &&
			q.nrzi != $past(q.nrzi) ##1 tx_level_o != $past(tx_level_o);
	endproperty
	a_mlt_step: assert property (p_mlt_step) else $error("line level did not step on a one"); // RL6 RL7
	property p_nibble_rate;
		@(posedge sys_clk_i) disable iff (rst_i)
		tx_take_o |=> !tx_take_o [*8] ##1 !tx_take_o ##1 tx_take_o;
	endproperty
	a_nibble_rate: assert property (p_nibble_rate) else $error("nibble period is not ten cycles"); // RL23
	property p_ssd_valid;
		@(posedge sys_clk_i) disable iff (rst_i)
		tick_w && q.lock && !q.in_frame && hist_n_w[9:0] == {CG_SSD1, CG_SSD2} && !(q.wdog == WDOG_LAST)
			|=> rx_dv_o && crs_o && rxd_o == NIB_PREAMBLE ##10 rxd_o == NIB_PREAMBLE;
	endproperty
	a_ssd_valid: assert property (p_ssd_valid) else $error("start delimiter not delivered as preamble"); // RL14
	property p_bad_ssd;
		@(posedge sys_clk_i) disable iff (rst_i)
		rx_er_o && !q.in_frame |-> rxd_o == NIB_BAD_SSD && !rx_dv_o;
	endproperty
	a_bad_ssd: assert property (p_bad_ssd) else $error("bad start delimiter answer wrong"); // RL21
	property p_frame_end;
		@(posedge sys_clk_i) disable iff (rst_i)
		$fell(q.in_frame) |-> !rx_dv_o && !crs_o;
	endproperty
	a_frame_end: assert property (p_frame_end) else $error("valid or carrier left high at frame end"); // RL16
	property p_wdog_abort;
		@(posedge sys_clk_i) disable iff (rst_i)
		q.lock && q.wdog == WDOG_LAST |=> !rx_lock_o && !rx_dv_o && !crs_o;
	endproperty
	a_wdog_abort: assert property (p_wdog_abort) else $error("watchdog expiry did not abort"); // RL10
	property p_dv_needs_lock;
		@(posedge sys_clk_i) disable iff (rst_i)
		rx_dv_o |-> rx_lock_o;
	endproperty
	a_dv_needs_lock: assert property (p_dv_needs_lock) else $error("data valid without descrambler lock"); // RL8
endmodule

/* shared/pcs_codec_pkg.sv */
package pcs_codec_pkg;
	localparam int CODE_W = 5;
	localparam int NIB_W = 4;
	localparam int ADDR_W = 5;
	localparam int LVL_W = 2;
	localparam int LFSR_W = 11;
	localparam int LFSR_TAP = 8;
	localparam logic [5:0] SEED_PAD = 6'h2a;
	localparam logic [4:0] CG_IDLE = 5'h1f;
	localparam logic [4:0] CG_SSD1 = 5'h18;
	localparam logic [4:0] CG_SSD2 = 5'h11;
	localparam logic [4:0] CG_ESD1 = 5'h0d;
	localparam logic [4:0] CG_ESD2 = 5'h07;
	localparam logic [4:0] CG_TXERR = 5'h04;
	localparam logic [3:0] NIB_PREAMBLE = 4'h5;
	localparam logic [3:0] NIB_BAD_SSD = 4'he;
	localparam logic [1:0] LVL_ZERO = 2'h0;
	localparam logic [1:0] LVL_POS = 2'h1;
	localparam logic [1:0] LVL_NEG = 2'h3;
	localparam logic [2:0] LAST_BIT = 3'h4;
	localparam int CLK_PERIOD_PS = 4000;
	localparam int SYM_PERIOD_PS = 8000;
	localparam int SYM_CYC = SYM_PERIOD_PS / CLK_PERIOD_PS;
	localparam int NIB_CYC = SYM_CYC * CODE_W;
	localparam int WDOG_WINDOW_NS = 40000;
	localparam int WDOG_CYC = (WDOG_WINDOW_NS * 1000) / CLK_PERIOD_PS;
	localparam logic [5:0] LOCK_RUN = 6'h20;
	localparam logic [1:0] IDLE_END_CNT = 2'h2;
endpackage

/* rtl/nibble_code_map.sv */
module nibble_code_map
	import pcs_codec_pkg::*;
(
	input wire logic [3:0] enc_nib_i,
	output logic [4:0] enc_cg_o,
	input wire logic [4:0] dec_cg_i,
	output logic [3:0] dec_nib_o,
	output logic dec_data_o
);
	logic [4:0] table_w [16];

	assign table_w = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
	assign enc_cg_o = table_w[enc_nib_i]; // RL18

	always_comb
	begin
		dec_nib_o = 4'h0;
		dec_data_o = 1'b0;
		for (int i = 0; i < 16; i++)
		begin
			if (table_w[i] == dec_cg_i)
			begin
				dec_nib_o = 4'(i); // RL18
				dec_data_o = 1'b1;
			end
		end
	end
endmodule

/* verif/mii_mac_model.sv */
module mii_mac_model
	import pcs_codec_pkg::*;
(
	input wire logic clk_i,
	input wire logic take_i,
	input wire logic [3:0] rxd_i,
	input wire logic rx_dv_i,
	input wire logic rx_er_i,
	output logic tx_en_o,
	output logic tx_er_o,
	output logic [3:0] txd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] tx_q[$];
	logic er_q[$];
	logic [3:0] rx_q[$];
	int er_cnt = 0;
	int ph = 0;
	initial
	begin
		tx_en_o = 1'b0;
		tx_er_o = 1'b0;
		txd_o = 4'h0;
	end
	////////////////////////////////////////////////////////////
	// new nibble only in a take cycle, held until the next one
	always @(negedge clk_i)
	begin
		if (take_i)
		begin
			tx_en_o = (tx_q.size() != 0);
			tx_er_o = 1'b0;
			if (tx_q.size() != 0)
			begin
				txd_o = tx_q.pop_front();
				tx_er_o = er_q.pop_front();
			end
			else
				txd_o = ~txd_o; // idle data toggles so stale values never match
		end
	end
	////////////////////////////////////////////////////////////
	// one sample per nibble period while valid
	always @(posedge clk_i)
	begin
		if (rx_dv_i !== 1'b1)
			ph = 0;
		else
		begin
			if (ph == 0)
			begin
				rx_q.push_back(rxd_i);
				if (rx_er_i === 1'b1)
					er_cnt++;
			end
			ph = (ph == NIB_CYC - 1) ? 0 : ph + 1;
		end
	end
endmodule

/* verif/fast_ethernet_pcs_codec_tb.sv */
module fast_ethernet_pcs_codec_tb
	import pcs_codec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, rst, tx_en, tx_er, tx_take, rx_dv, rx_er, crs, rx_lock, lock_q;
	logic [4:0] phy_addr;
	logic [3:0] txd, rxd;
	logic [1:0] tx_level, rx_level, prev_lvl, last_nz;
	logic [127:0] sig_a, sig_b;
	int n_mismatch = 0;
	int n_checks = 0;
	int seed = 65360;
	int lock_drops = 0;
	fast_ethernet_pcs_codec #(.WDOG_LIMIT(400)) DUT (.sys_clk_i(sys_clk), .rst_i(rst), .phy_addr_i(phy_addr),
		.tx_en_i(tx_en), .tx_er_i(tx_er), .txd_i(txd), .tx_take_o(tx_take), .tx_level_o(tx_level),
		.rx_level_i(rx_level), .rxd_o(rxd), .rx_dv_o(rx_dv), .rx_er_o(rx_er), .crs_o(crs), .rx_lock_o(rx_lock));
	mii_mac_model MAC (.clk_i(sys_clk), .take_i(tx_take), .rxd_i(rxd), .rx_dv_i(rx_dv), .rx_er_i(rx_er),
		.tx_en_o(tx_en), .tx_er_o(tx_er), .txd_o(txd));
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// line loopback: the receiver must find its own key, seeds differ anyway
	always @(negedge sys_clk)
		rx_level <= tx_level;
	////////////////////////////////////////////////////////////
	function automatic logic [1:0] mlt_step(input logic [1:0] cur, input logic [1:0] nz);
		if (cur != LVL_ZERO)
			return LVL_ZERO;
		return (nz == LVL_POS) ? LVL_NEG : LVL_POS;
	endfunction
	task automatic bad(input logic [15:0] got, input logic [15:0] exp);
		n_mismatch++;
		$display("mismatch at %0t: got %h expected %h", $time, got, exp);
	endtask
	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
			bad(got, exp);
	endtask
	task automatic check_nib(input logic [3:0] got, input logic [3:0] exp);
		n_checks++;
		if (got !== exp)
			bad(16'(got), 16'(exp));
	endtask
	task automatic check_lvl(input logic [1:0] got, input logic [1:0] exp);
		n_checks++;
		if (got !== exp)
			bad(16'(got), 16'(exp));
	endtask
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			prev_lvl <= LVL_ZERO;
			last_nz <= LVL_NEG;
		end
		else if (tx_level !== prev_lvl)
		begin
			check_lvl(tx_level, mlt_step(prev_lvl, last_nz));
			prev_lvl <= tx_level;
			if (tx_level != LVL_ZERO)
				last_nz <= tx_level;
		end
		lock_q <= rx_lock;
		if (!rst && lock_q === 1'b1 && rx_lock === 1'b0)
			lock_drops++;
	end
	////////////////////////////////////////////////////////////
	task automatic do_reset(input logic [4:0] addr, output logic [127:0] sig);
		@(negedge sys_clk);
		rst = 1'b1;
		phy_addr = addr;
		repeat (5) @(negedge sys_clk);
		rst = 1'b0;
		repeat (64) @(negedge sys_clk)
			sig = {sig[125:0], tx_level};
	endtask
	task automatic wait_lock();
		int t;
		t = 0;
		while (rx_lock !== 1'b1 && t < 3000)
		begin
			@(negedge sys_clk);
			t++;
		end
		check_val(16'(rx_lock), 16'h1);
	endtask
	task automatic run_frame(input int n, input int er_at, input bit cmp);
		logic [3:0] exp_q[$];
		logic [3:0] d;
		int t;
		MAC.rx_q.delete();
		MAC.er_cnt = 0;
		for (int i = 0; i < n + 2; i++)
		begin
			// code 01001 never shows five ones in a row, so the idle watchdog must fire
			d = (i < 2) ? NIB_PREAMBLE : (n == 16 ? 4'(i - 2) : (cmp ? 4'($random(seed)) : 4'h1));
			MAC.tx_q.push_back(d);
			MAC.er_q.push_back(er_at >= 0 && i == er_at + 2);
			exp_q.push_back(d);
		end
		t = 0;
		while ((MAC.tx_q.size() != 0 || crs !== 1'b0) && t < 3000)
		begin
			@(negedge sys_clk);
			t++;
		end
		check_val(16'(t < 3000), 16'h1);
		check_val(16'(rx_dv), 16'h0);
		check_val(16'(rx_lock), 16'(cmp));
		if (cmp)
		begin
			check_val(16'(rx_er), 16'h0);
			check_val(16'(MAC.rx_q.size()), 16'(exp_q.size()));
			foreach (exp_q[i])
				if (i < MAC.rx_q.size() && !(er_at >= 0 && i == er_at + 2))
					check_nib(MAC.rx_q[i], exp_q[i]);
			check_val(16'(MAC.er_cnt), 16'(er_at >= 0));
		end
		$display("frame of %0d nibbles done", n);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial
	begin
		rst = 1'b1;
		phy_addr = 5'h00;
		do_reset(5'($random(seed)), sig_a);
		wait_lock();
		run_frame(16, -1, 1'b1);
		run_frame(24, -1, 1'b1);
		run_frame(20, 5, 1'b1);
		// longer than the idle window, so the receiver has to give up
		run_frame(60, -1, 1'b0);
		check_val(16'(lock_drops), 16'h1);
		wait_lock();
		run_frame(18, 0, 1'b1);
		run_frame(30, -1, 1'b1);
		do_reset(phy_addr ^ 5'h01, sig_b);
		check_val(16'(sig_a != sig_b), 16'h1);
		$display("seed test done");
		give_verdict();
	end
	initial
	begin
		#100000;
		n_mismatch++;
		give_verdict();
	end
endmodule
